/* File: core/hpf_coef_byte.sv */
// One byte-wide read/write coefficient register with a fixed reset value
`timescale 1ns/1ps
module hpf_coef_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wdata;
    end
  end
endmodule

/* File: core/hpf_coeff_bank.sv */
// Left and right ADC high-pass coefficient registers on page 1
//
// Behaviour
// - Each coefficient is a signed 16-bit value: high byte over low byte.
// - Left coefficients sit at registers 65 to 70: ff0, ff1, fb1, high then low.
// - Left ff0 resets to high 0x39, low 0x55.
// - Left ff1 resets to high 0xF3, low 0x2D.
// - Left fb1 resets to high 0x53, low 0x7E.
// - Right set at registers 71 to 76, same order and reset values.
// - Every coefficient register is eight bits, readable and writable by host.
// - Registers 77 to 127 are read-only reserved and read as zero.
`timescale 1ns/1ps
`include "hpf_coeff_regs.svh"
module hpf_coeff_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_rd_hit,
  output logic rsvd_wr_seen,
  output hpf_pkg::hpf_coeff_t left_ff0,
  output hpf_pkg::hpf_coeff_t left_ff1,
  output hpf_pkg::hpf_coeff_t left_fb1,
  output hpf_pkg::hpf_coeff_t right_ff0,
  output hpf_pkg::hpf_coeff_t right_ff1,
  output hpf_pkg::hpf_coeff_t right_fb1
);
  hpf_pkg::hpf_byte_t left_hpf_ff0_high_r;
  hpf_pkg::hpf_byte_t left_hpf_ff0_low_r;
  hpf_pkg::hpf_byte_t left_hpf_ff1_high_r;
  hpf_pkg::hpf_byte_t left_hpf_ff1_low_r;
  hpf_pkg::hpf_byte_t left_hpf_fb1_high_r;
  hpf_pkg::hpf_byte_t left_hpf_fb1_low_r;
  hpf_pkg::hpf_byte_t right_hpf_ff0_high_r;
  hpf_pkg::hpf_byte_t right_hpf_ff0_low_r;
  hpf_pkg::hpf_byte_t right_hpf_ff1_high_r;
  hpf_pkg::hpf_byte_t right_hpf_ff1_low_r;
  hpf_pkg::hpf_byte_t right_hpf_fb1_high_r;
  hpf_pkg::hpf_byte_t right_hpf_fb1_low_r;
  hpf_pkg::hpf_area_e area;

  // Classify the register number against the bank and the reserved range
  always_comb begin
    if (reg_addr >= `HPF_ADDR_L_FF0_HI && reg_addr <= `HPF_ADDR_R_FB1_LO) begin
      area = hpf_pkg::HPF_AREA_COEF;
    end else if (reg_addr >= `HPF_ADDR_RSVD_FIRST && reg_addr <= `HPF_ADDR_RSVD_LAST) begin
      area = hpf_pkg::HPF_AREA_RSVD;
    end else begin
      area = hpf_pkg::HPF_AREA_NONE;
    end
  end

  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF0_HI)) u_l_ff0_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FF0_HI),
    .wdata(reg_wdata),
    .q(left_hpf_ff0_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF0_LO)) u_l_ff0_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FF0_LO),
    .wdata(reg_wdata),
    .q(left_hpf_ff0_low_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF1_HI)) u_l_ff1_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FF1_HI),
    .wdata(reg_wdata),
    .q(left_hpf_ff1_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF1_LO)) u_l_ff1_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FF1_LO),
    .wdata(reg_wdata),
    .q(left_hpf_ff1_low_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FB1_HI)) u_l_fb1_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FB1_HI),
    .wdata(reg_wdata),
    .q(left_hpf_fb1_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FB1_LO)) u_l_fb1_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_L_FB1_LO),
    .wdata(reg_wdata),
    .q(left_hpf_fb1_low_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF0_HI)) u_r_ff0_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FF0_HI),
    .wdata(reg_wdata),
    .q(right_hpf_ff0_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF0_LO)) u_r_ff0_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FF0_LO),
    .wdata(reg_wdata),
    .q(right_hpf_ff0_low_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF1_HI)) u_r_ff1_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FF1_HI),
    .wdata(reg_wdata),
    .q(right_hpf_ff1_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FF1_LO)) u_r_ff1_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FF1_LO),
    .wdata(reg_wdata),
    .q(right_hpf_ff1_low_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FB1_HI)) u_r_fb1_hi (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FB1_HI),
    .wdata(reg_wdata),
    .q(right_hpf_fb1_high_r)
  );
  hpf_coef_byte #(.RESET_VAL(`HPF_RST_FB1_LO)) u_r_fb1_lo (
    .clk(clk),
    .reset(reset),
    .wr_en(reg_wr && reg_addr == `HPF_ADDR_R_FB1_LO),
    .wdata(reg_wdata),
    .q(right_hpf_fb1_low_r)
  );

  assign left_ff0 = hpf_pkg::hpf_coeff_t'({left_hpf_ff0_high_r, left_hpf_ff0_low_r});
  assign left_ff1 = hpf_pkg::hpf_coeff_t'({left_hpf_ff1_high_r, left_hpf_ff1_low_r});
  assign left_fb1 = hpf_pkg::hpf_coeff_t'({left_hpf_fb1_high_r, left_hpf_fb1_low_r});
  assign right_ff0 = hpf_pkg::hpf_coeff_t'({right_hpf_ff0_high_r, right_hpf_ff0_low_r});
  assign right_ff1 = hpf_pkg::hpf_coeff_t'({right_hpf_ff1_high_r, right_hpf_ff1_low_r});
  assign right_fb1 = hpf_pkg::hpf_coeff_t'({right_hpf_fb1_high_r, right_hpf_fb1_low_r});

  // read data registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `HPF_RSVD_VALUE;
    end else if (reg_rd) begin
      if (reg_addr == `HPF_ADDR_L_FF0_HI) begin
        reg_rdata <= left_hpf_ff0_high_r;
      end else if (reg_addr == `HPF_ADDR_L_FF0_LO) begin
        reg_rdata <= left_hpf_ff0_low_r;
      end else if (reg_addr == `HPF_ADDR_L_FF1_HI) begin
        reg_rdata <= left_hpf_ff1_high_r;
      end else if (reg_addr == `HPF_ADDR_L_FF1_LO) begin
        reg_rdata <= left_hpf_ff1_low_r;
      end else if (reg_addr == `HPF_ADDR_L_FB1_HI) begin
        reg_rdata <= left_hpf_fb1_high_r;
      end else if (reg_addr == `HPF_ADDR_L_FB1_LO) begin
        reg_rdata <= left_hpf_fb1_low_r;
      end else if (reg_addr == `HPF_ADDR_R_FF0_HI) begin
        reg_rdata <= right_hpf_ff0_high_r;
      end else if (reg_addr == `HPF_ADDR_R_FF0_LO) begin
        reg_rdata <= right_hpf_ff0_low_r;
      end else if (reg_addr == `HPF_ADDR_R_FF1_HI) begin
        reg_rdata <= right_hpf_ff1_high_r;
      end else if (reg_addr == `HPF_ADDR_R_FF1_LO) begin
        reg_rdata <= right_hpf_ff1_low_r;
      end else if (reg_addr == `HPF_ADDR_R_FB1_HI) begin
        reg_rdata <= right_hpf_fb1_high_r;
      end else if (reg_addr == `HPF_ADDR_R_FB1_LO) begin
        reg_rdata <= right_hpf_fb1_low_r;
      end else begin
        // reserved and unowned numbers read zero
        reg_rdata <= `HPF_RSVD_VALUE;
      end
    end
  end

  // Read acknowledge and ownership flag, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rd_valid <= 1'b0;
      reg_rd_hit <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      reg_rd_hit <= reg_rd && (area != hpf_pkg::HPF_AREA_NONE);
    end
  end

  // reserved writes are dropped and flagged for one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rsvd_wr_seen <= 1'b0;
    end else begin
      rsvd_wr_seen <= reg_wr && (area == hpf_pkg::HPF_AREA_RSVD);
    end
  end
endmodule

/* File: core/hpf_coeff_regs.svh */
// Offsets, reset values and widths of the high-pass coefficient bank
`ifndef HPF_COEFF_REGS_SVH
`define HPF_COEFF_REGS_SVH

`define HPF_ADDR_W 7
`define HPF_DATA_W 8
`define HPF_COEFF_W 16

`define HPF_ADDR_L_FF0_HI 7'h41
`define HPF_ADDR_L_FF0_LO 7'h42
`define HPF_ADDR_L_FF1_HI 7'h43
`define HPF_ADDR_L_FF1_LO 7'h44
`define HPF_ADDR_L_FB1_HI 7'h45
`define HPF_ADDR_L_FB1_LO 7'h46
`define HPF_ADDR_R_FF0_HI 7'h47
`define HPF_ADDR_R_FF0_LO 7'h48
`define HPF_ADDR_R_FF1_HI 7'h49
`define HPF_ADDR_R_FF1_LO 7'h4A
`define HPF_ADDR_R_FB1_HI 7'h4B
`define HPF_ADDR_R_FB1_LO 7'h4C
`define HPF_ADDR_RSVD_FIRST 7'h4D
`define HPF_ADDR_RSVD_LAST 7'h7F

`define HPF_RST_FF0_HI 8'h39
`define HPF_RST_FF0_LO 8'h55
`define HPF_RST_FF1_HI 8'hF3
`define HPF_RST_FF1_LO 8'h2D
`define HPF_RST_FB1_HI 8'h53
`define HPF_RST_FB1_LO 8'h7E
`define HPF_RSVD_VALUE 8'h00

`endif

/* File: core/hpf_pkg.sv */
// Types shared by the high-pass coefficient bank
package hpf_pkg;
  typedef logic [7:0] hpf_byte_t;
  typedef logic signed [15:0] hpf_coeff_t;
  typedef logic [6:0] hpf_addr_t;
  typedef enum logic [2:0] {
    HPF_AREA_NONE = 3'b001,
    HPF_AREA_COEF = 3'b010,
    HPF_AREA_RSVD = 3'b100
  } hpf_area_e;
endpackage

/* File: sim/hpf_bank_assertions.sv */
// Checker for the coefficient bank register port
`timescale 1ns/1ps
module hpf_bank_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic reg_rd_hit,
  input wire logic rsvd_wr_seen,
  input wire hpf_pkg::hpf_coeff_t left_ff0,
  input wire hpf_pkg::hpf_coeff_t right_fb1
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rd; reg_rd |=> reg_rd_valid && reg_rd_hit == ($past(reg_addr) > 7'h40); endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_pulse; !reg_rd |=> !reg_rd_valid && !reg_rd_hit; endproperty
  a_pulse: assert property (p_pulse) else $error("read answer stood too long");
  property p_rsvd_rd; reg_rd && reg_addr > 7'h4C |=> reg_rdata == 8'h00; endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved read");
  property p_rsvd_wr; reg_wr && reg_addr > 7'h4C |=> rsvd_wr_seen; endproperty
  a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved write");
  property p_ff0_wr; reg_wr && reg_addr == 7'h41 |=> left_ff0[15:8] == $past(reg_wdata); endproperty
  a_ff0_wr: assert property (p_ff0_wr) else $error("left ff0 write");
  property p_fb1_wr; reg_wr && reg_addr == 7'h4C |=> right_fb1[7:0] == $past(reg_wdata); endproperty
  a_fb1_wr: assert property (p_fb1_wr) else $error("right fb1 write");
  property p_hold; !(reg_wr && reg_addr inside {7'h41, 7'h42}) |=> $stable(left_ff0); endproperty
  a_hold: assert property (p_hold) else $error("left ff0 moved");
  property p_back; reg_rd && reg_addr == 7'h42 |=> reg_rdata == $past(left_ff0[7:0]); endproperty
  a_back: assert property (p_back) else $error("read back");
  property p_rst; $fell(reset) |-> left_ff0 == 16'h3955 && right_fb1 == 16'h537E; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  cover property (reg_wr && reg_addr == 7'h41);
  cover property (reg_rd && reg_wr);
  cover property (rsvd_wr_seen);
endmodule
bind hpf_coeff_bank hpf_bank_assertions chk (.*);

/* File: sim/hpf_host_model.sv */
// Host processor model driving the register strobe port
`timescale 1ns/1ps
module hpf_host_model (
  input wire logic clk,
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  task automatic op(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d, input logic bad);
    @(posedge clk);
    reg_wr <= w && (bad || a < 7'h4D);
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
endmodule

/* File: sim/testbench.sv */
// Random and corner-case bench for the coefficient bank
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] reg_addr;
  logic reg_wr, reg_rd, reg_rd_valid, reg_rd_hit, rsvd_wr_seen;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] lfsr = 8'h51;
  logic [7:0] mem [0:127];
  hpf_pkg::hpf_coeff_t left_ff0, left_ff1, left_fb1, right_ff0, right_ff1, right_fb1;
  int num_errors = 0;
  int n_checks = 0;
  hpf_host_model host (.*);
  hpf_coeff_bank dut (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle();
    host.op(1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
    #1;
  endtask
  function automatic logic [7:0] rst_val(input int a);
    logic [7:0] t [0:5];
    t = '{8'h39, 8'h55, 8'hF3, 8'h2D, 8'h53, 8'h7E};
    return (a > 64 && a < 77) ? t[(a - 65) % 6] : 8'h00;
  endfunction
  task automatic rst_bank();
    idle();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 128; a++) mem[a] = rst_val(a);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic bad);
    host.op(1'b1, 1'b0, a, d, bad);
    if (a > 64 && a < 77) mem[a] = d;
  endtask
  task automatic coef();
    logic [95:0] e;
    idle();
    for (int i = 65; i < 77; i++) e = {e[87:0], mem[i]};
    chk("coef", e, {left_ff0, left_ff1, left_fb1, right_ff0, right_ff1, right_fb1});
  endtask
  task automatic sweep();
    for (int a = 0; a < 128; a++) begin
      host.op(1'b0, 1'b1, 7'(a), 8'h00, 1'b0);
      idle();
      chk("read", {1'b1, a > 64, mem[a]}, {reg_rd_valid, reg_rd_hit, reg_rdata});
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    rst_bank();
    coef();
    sweep();
    for (int b = 0; b < 8; b++) begin
      repeat (24) begin
        lfsr = nxt(lfsr);
        wr(7'(65 + lfsr % 12), nxt(lfsr), 1'b0);
      end
      coef();
      sweep();
    end
    host.op(1'b1, 1'b1, 7'h43, 8'hA5, 1'b0);
    idle();
    chk("rd_wr", mem[67], reg_rdata);
    mem[67] = 8'hA5;
    coef();
    for (int a = 77; a < 128; a += 50) begin
      wr(7'(a), lfsr, 1'b1);
      idle();
      chk("rsvd_wr", 1'b1, rsvd_wr_seen);
    end
    wr(7'h40, lfsr, 1'b0);
    idle();
    chk("low_wr", 1'b0, rsvd_wr_seen);
    sweep();
    wr(7'h41, 8'h00, 1'b0);
    rst_bank();
    coef();
    sweep();
    summarize();
  end
endmodule
